// ### rtl/psw_pkg.sv
// constants, types and decode functions for the port-split link watchdog
// assumes a 10 MHz core clock and 16-bit hub register addresses
`default_nettype none

package psw_pkg;

   // register map and widths
   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 8;
   localparam int          LINK_W          = 4;
   localparam int          MS_W            = 12;
   localparam int          TMO_FIELD_W     = 3;
   localparam logic [15:0] REG_P3_SEL      = 16'h416D;
   localparam logic [15:0] REG_P4_SEL      = 16'h416E;
   localparam logic [15:0] REG_TIMEOUT     = 16'h4171;
   localparam logic [15:0] REG_TOGGLE      = 16'h4176;

   // reset values
   localparam logic [7:0]  SEL_RESET       = 8'h00;
   localparam logic [2:0]  TIMEOUT_RESET   = 3'h5;
   localparam logic [7:0]  TOGGLE_RESET    = 8'h05;

   // pin select codes per port
   localparam logic [7:0]  P3_SEL_OPT_A    = 8'h42;
   localparam logic [7:0]  P3_SEL_OPT_B    = 8'h05;
   localparam logic [7:0]  P4_SEL_OPT_A    = 8'h06;
   localparam logic [7:0]  P4_SEL_OPT_B    = 8'h04;

   // link states counted as stuck
   localparam logic [3:0]  LINK_STUCK_LO   = 4'h4;
   localparam logic [3:0]  LINK_STUCK_HI   = 4'h9;

   // timeout choices in milliseconds
   localparam logic [11:0] TMO_SEL1_MS     = 12'h064;
   localparam logic [11:0] TMO_SEL2_MS     = 12'h0FA;
   localparam logic [11:0] TMO_SEL3_MS     = 12'h1F4;
   localparam logic [11:0] TMO_SEL4_MS     = 12'h2EE;
   localparam logic [11:0] TMO_SEL5_MS     = 12'h3E8;
   localparam logic [11:0] TMO_SEL6_MS     = 12'h7D0;
   localparam logic [11:0] TMO_NONE_MS     = 12'h000;

   // power-off pulse length in milliseconds
   localparam logic [11:0] TOGGLE_BASE_MS  = 12'h15E;
   localparam logic [11:0] TOGGLE_STEP_MS  = 12'h00A;

   // millisecond tick derived from the core clock
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          MS_TICK_NS      = 1000000;
   localparam int          MS_TICK_CYCLES  = MS_TICK_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {PSW_OFF, PSW_WATCH, PSW_PULSE} psw_wd_state_t;

   // timeout field to milliseconds, zero meaning never
   function automatic logic [11:0] psw_timeout_ms(input logic [2:0] sel);
      logic [11:0] ms;
      unique case (sel)
         3'h1:    ms = TMO_SEL1_MS;
         3'h2:    ms = TMO_SEL2_MS;
         3'h3:    ms = TMO_SEL3_MS;
         3'h4:    ms = TMO_SEL4_MS;
         3'h5:    ms = TMO_SEL5_MS;
         3'h6:    ms = TMO_SEL6_MS;
         default: ms = TMO_NONE_MS;
      endcase
      return ms;
   endfunction

   // toggle field to milliseconds
   function automatic logic [11:0] psw_toggle_ms(input logic [7:0] val);
      return TOGGLE_BASE_MS + (12'(val) * TOGGLE_STEP_MS);
   endfunction

   // pin select decode: bit 0 option a, bit 1 option b
   function automatic logic [1:0] psw_sel_decode(input logic [7:0] val,
                                                 input logic [7:0] opt_a,
                                                 input logic [7:0] opt_b);
      return {val == opt_b, val == opt_a};
   endfunction

endpackage

`default_nettype wire

// ### rtl/psw_wd_if.sv
// carrier between the top and one per-port link watchdog
// assumes both ends share the core clock
`timescale 1ns/100ps
`default_nettype none

interface psw_wd_if;
   logic        enable;      // splitting on for this port
   logic [11:0] timeout_ms;  // zero disables the watchdog
   logic [11:0] toggle_ms;   // power-off pulse length
   logic        ms_tick;     // one-cycle pulse each millisecond
   logic [3:0]  link_state;  // link state of the port
   logic        power_on;    // split power enable level

   modport top (output enable, timeout_ms, toggle_ms, ms_tick, link_state,
                input power_on);
   modport wd  (input enable, timeout_ms, toggle_ms, ms_tick, link_state,
                output power_on);
endinterface

`default_nettype wire

// ### rtl/psw_link_wd.sv
// per-port link watchdog driving the superspeed split power enable
// assumes a one-cycle millisecond tick from the top
`timescale 1ns/100ps
`default_nettype none

module psw_link_wd (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   psw_wd_if.wd      wd
);
   import psw_pkg::*;

   psw_wd_state_t state, next_state;
   logic [3:0]    prev_link, next_prev_link;
   logic [11:0]   stuck_cnt, next_stuck_cnt;
   logic [11:0]   pulse_cnt, next_pulse_cnt;
   logic          power_on, next_power_on;
   logic          stuck;

   // unchanged link sitting in a stuck state, watchdog armed
   assign stuck = (wd.link_state >= LINK_STUCK_LO) && (wd.link_state <= LINK_STUCK_HI)
                  && (wd.link_state == prev_link) && (wd.timeout_ms != TMO_NONE_MS);

   // next state of the watchdog
   always_comb begin
      next_state     = state;
      next_prev_link = wd.link_state;
      next_stuck_cnt = stuck_cnt;
      next_pulse_cnt = pulse_cnt;
      next_power_on  = power_on;
      unique case (state)
         PSW_OFF: begin
            next_stuck_cnt = '0;
            next_pulse_cnt = '0;
            next_power_on  = 1'b0;
            if (wd.enable) begin
               next_state    = PSW_WATCH;
               next_power_on = 1'b1;
            end
         end
         PSW_WATCH: begin
            if (!wd.enable) begin
               next_state    = PSW_OFF;
               next_power_on = 1'b0;
            end else if (!stuck) begin
               next_stuck_cnt = '0;
            end else if (wd.ms_tick) begin
               if (stuck_cnt + 12'h001 >= wd.timeout_ms) begin
                  next_state     = PSW_PULSE;
                  next_stuck_cnt = '0;
                  next_pulse_cnt = '0;
                  next_power_on  = 1'b0;
               end else begin
                  next_stuck_cnt = stuck_cnt + 12'h001;
               end
            end
         end
         PSW_PULSE: begin
            if (!wd.enable) begin
               next_state     = PSW_OFF;
               next_pulse_cnt = '0;
               next_power_on  = 1'b0;
            end else if (wd.ms_tick) begin
               if (pulse_cnt + 12'h001 >= wd.toggle_ms) begin
                  next_state     = PSW_WATCH;
                  next_pulse_cnt = '0;
                  next_stuck_cnt = '0;
                  next_power_on  = 1'b1;
               end else begin
                  next_pulse_cnt = pulse_cnt + 12'h001;
               end
            end
         end
      endcase
   end

   // watchdog registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state     <= PSW_OFF;
         prev_link <= '0;
         stuck_cnt <= '0;
         pulse_cnt <= '0;
         power_on  <= 1'b0;
      end else begin
         state     <= next_state;
         prev_link <= next_prev_link;
         stuck_cnt <= next_stuck_cnt;
         pulse_cnt <= next_pulse_cnt;
         power_on  <= next_power_on;
      end
   end

   assign wd.power_on = power_on;

endmodule // psw_link_wd

`default_nettype wire

// ### rtl/psw_port_split_wd.sv
// port-split power control with link watchdog for downstream ports 3 and 4
// assumes config writes arrive on a simple register port fed by smbus or otp
// Notes on behaviour
// - only ports 3 and 4 can be split; no other port has split power.
// - splitting is set by smbus register writes or from otp.
// - the usb 2.0 power pin keeps its unsplit behaviour when split.
// - splitting enables a split power output on the selected gpio pin.
// - the split power pin is output only, no overcurrent sensing.
// - no valid link for the timeout pulses the split power pin low.
// - the timeout counter clears and restarts each time it expires.
// - link invalid when held in one state 0x4 to 0x9 whole timeout.
// - timeout field: none,100,250,500,750ms,1s,2s, 111 reserved.
// - timeout resets to 0x05; 0x00 disables pulsing entirely.
// - otp can replace the timeout register value.
// - one global timeout for all split ports; bits 7:3 read zero.
// - pulse holds the split pin low for the toggle time, then restores.
// - pulse length is 350ms plus 10ms per field step.
// - toggle time defaults to 400ms, spans 350ms to 2.9s.
// - pulse counter clears when a power-off pulse completes.
`timescale 1ns/100ps
`default_nettype none

module psw_port_split_wd #(
   parameter int MS_TICK_CYCLES = psw_pkg::MS_TICK_CYCLES
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   // register port written by smbus during configuration or by otp
   input  wire logic                       cfg_wr_i,
   input  wire logic                       cfg_rd_i,
   input  wire logic [psw_pkg::ADDR_W-1:0] cfg_addr_i,
   input  wire logic [psw_pkg::DATA_W-1:0] cfg_wdata_i,
   output logic      [psw_pkg::DATA_W-1:0] cfg_rdata_o,
   output logic                            cfg_rvalid_o,
   // otp override of the timeout register
   input  wire logic                       otp_timeout_load_i,
   input  wire logic [psw_pkg::DATA_W-1:0] otp_timeout_i,
   // usb 2.0 power requests and pins, index 0 port 3, index 1 port 4
   input  wire logic [1:0]                 usb2_power_req_i,
   output logic      [1:0]                 port_power_ctl_pin_o,
   // link state of each port
   input  wire logic [psw_pkg::LINK_W-1:0] port3_link_state_status_i,
   input  wire logic [psw_pkg::LINK_W-1:0] port4_link_state_status_i,
   // split power pins, level and enable
   output logic                            port3_option_a_pin_o,
   output logic                            port3_option_a_pin_oe_o,
   output logic                            port3_option_b_pin_o,
   output logic                            port3_option_b_pin_oe_o,
   output logic                            port4_option_a_pin_o,
   output logic                            port4_option_a_pin_oe_o,
   output logic                            port4_option_b_pin_o,
   output logic                            port4_option_b_pin_oe_o
);
   import psw_pkg::*;

   localparam int TICK_W = $clog2(MS_TICK_CYCLES + 1);

   // configuration registers
   logic [7:0] port3_split_pin_select, next_port3_split_pin_select;
   logic [7:0] port4_split_pin_select, next_port4_split_pin_select;
   logic [2:0] split_link_timeout_config, next_split_link_timeout_config;
   logic [7:0] split_power_off_duration, next_split_power_off_duration;
   logic [7:0] rdata, next_rdata;
   logic       rvalid, next_rvalid;

   // millisecond divider
   logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
   logic              ms_tick, next_ms_tick;

   // pin decode and output flops
   logic [1:0] p3_sel, p4_sel;
   logic [1:0] pwr_ctl, next_pwr_ctl;
   logic [3:0] pins, next_pins;        // {p4b, p4a, p3b, p3a}
   logic [3:0] pins_oe, next_pins_oe;
   logic [1:0] power_on;
   logic [3:0] link_state [2];

   psw_wd_if wd_if [2] ();

   assign p3_sel = psw_sel_decode(port3_split_pin_select, P3_SEL_OPT_A, P3_SEL_OPT_B);
   assign p4_sel = psw_sel_decode(port4_split_pin_select, P4_SEL_OPT_A, P4_SEL_OPT_B);
   assign link_state[0] = port3_link_state_status_i;
   assign link_state[1] = port4_link_state_status_i;

   // register writes, otp override and reads
   always_comb begin
      next_port3_split_pin_select    = port3_split_pin_select;
      next_port4_split_pin_select    = port4_split_pin_select;
      next_split_link_timeout_config = split_link_timeout_config;
      next_split_power_off_duration  = split_power_off_duration;
      next_rdata                     = '0;
      next_rvalid                    = cfg_rd_i;
      if (cfg_wr_i) begin
         unique case (cfg_addr_i)
            REG_P3_SEL:  next_port3_split_pin_select    = cfg_wdata_i;
            REG_P4_SEL:  next_port4_split_pin_select    = cfg_wdata_i;
            REG_TIMEOUT: next_split_link_timeout_config = cfg_wdata_i[TMO_FIELD_W-1:0];
            REG_TOGGLE:  next_split_power_off_duration  = cfg_wdata_i;
            default:     ;
         endcase
      end
      if (otp_timeout_load_i) begin
         next_split_link_timeout_config = otp_timeout_i[TMO_FIELD_W-1:0];
      end
      if (cfg_rd_i) begin
         unique case (cfg_addr_i)
            REG_P3_SEL:  next_rdata = port3_split_pin_select;
            REG_P4_SEL:  next_rdata = port4_split_pin_select;
            REG_TIMEOUT: next_rdata = {5'h00, split_link_timeout_config};
            REG_TOGGLE:  next_rdata = split_power_off_duration;
            default:     next_rdata = '0;
         endcase
      end
   end

   // configuration registers and read data
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         port3_split_pin_select    <= SEL_RESET;
         port4_split_pin_select    <= SEL_RESET;
         split_link_timeout_config <= TIMEOUT_RESET;
         split_power_off_duration  <= TOGGLE_RESET;
         rdata                     <= '0;
         rvalid                    <= 1'b0;
      end else begin
         port3_split_pin_select    <= next_port3_split_pin_select;
         port4_split_pin_select    <= next_port4_split_pin_select;
         split_link_timeout_config <= next_split_link_timeout_config;
         split_power_off_duration  <= next_split_power_off_duration;
         rdata                     <= next_rdata;
         rvalid                    <= next_rvalid;
      end
   end

   assign cfg_rdata_o  = rdata;
   assign cfg_rvalid_o = rvalid;

   // one-cycle tick every millisecond
   always_comb begin
      next_ms_tick  = 1'b0;
      next_tick_cnt = tick_cnt + TICK_W'(1);
      if (tick_cnt == TICK_W'(MS_TICK_CYCLES - 1)) begin
         next_tick_cnt = '0;
         next_ms_tick  = 1'b1;
      end
   end

   // divider registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt <= '0;
         ms_tick  <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         ms_tick  <= next_ms_tick;
      end
   end

   // one watchdog per splittable port, sharing the global timeout
   for (genvar p = 0; p < 2; p++) begin : g_port
      assign wd_if[p].enable     = (p == 0) ? |p3_sel : |p4_sel;
      assign wd_if[p].timeout_ms = psw_timeout_ms(split_link_timeout_config);
      assign wd_if[p].toggle_ms  = psw_toggle_ms(split_power_off_duration);
      assign wd_if[p].ms_tick    = ms_tick;
      assign wd_if[p].link_state = link_state[p];
      assign power_on[p]         = wd_if[p].power_on;

      psw_link_wd u_wd (
         .clk_i   (clk_i),
         .rst_n_i (rst_n_i),
         .wd      (wd_if[p].wd)
      );
   end

   // pin routing: split power only on the selected gpio, usb 2.0 untouched
   always_comb begin
      next_pwr_ctl = usb2_power_req_i;
      next_pins_oe = {p4_sel, p3_sel};
      next_pins    = {p4_sel & {2{power_on[1]}}, p3_sel & {2{power_on[0]}}};
   end

   // output flops; split pins are drive-only, no sense path
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_ctl <= '0;
         pins    <= '0;
         pins_oe <= '0;
      end else begin
         pwr_ctl <= next_pwr_ctl;
         pins    <= next_pins;
         pins_oe <= next_pins_oe;
      end
   end

   assign port_power_ctl_pin_o    = pwr_ctl;
   assign port3_option_a_pin_o    = pins[0];
   assign port3_option_a_pin_oe_o = pins_oe[0];
   assign port3_option_b_pin_o    = pins[1];
   assign port3_option_b_pin_oe_o = pins_oe[1];
   assign port4_option_a_pin_o    = pins[2];
   assign port4_option_a_pin_oe_o = pins_oe[2];
   assign port4_option_b_pin_o    = pins[3];
   assign port4_option_b_pin_oe_o = pins_oe[3];

endmodule // psw_port_split_wd

`default_nettype wire

// ### testbench/psw_port_split_wd_monitor.sv
// checker for the port-split watchdog, watching the top module ports only
// assumes pulses are exercised on port 3 option a and port 4 option b
`timescale 1ns/100ps
`default_nettype none

module psw_monitor
   import psw_pkg::*;
#(
   parameter int MS_TICK_CYCLES = 10
) (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        cfg_wr_i,
   input wire logic        cfg_rd_i,
   input wire logic [15:0] cfg_addr_i,
   input wire logic [7:0]  cfg_wdata_i,
   input wire logic [7:0]  cfg_rdata_o,
   input wire logic        cfg_rvalid_o,
   input wire logic        otp_timeout_load_i,
   input wire logic [7:0]  otp_timeout_i,
   input wire logic [1:0]  usb2_power_req_i,
   input wire logic [1:0]  port_power_ctl_pin_o,
   input wire logic [3:0]  port3_link_state_status_i,
   input wire logic        port3_option_a_pin_o,
   input wire logic        port3_option_a_pin_oe_o,
   input wire logic        port4_option_b_pin_o,
   input wire logic        port4_option_b_pin_oe_o
);
   logic [7:0] tog_q;
   logic [2:0] tmo_q;
   logic [3:0] lnk_d;
   int         low_cnt;
   int         stk_cnt;
   int         tmo_cyc;
   int         tog_cyc;
   wire        p3a_up = port3_option_a_pin_oe_o && port3_option_a_pin_o;

   // expected timeout and pulse length in clock cycles
   always_comb begin
      case (tmo_q)
         3'h1: tmo_cyc = 100 * MS_TICK_CYCLES;
         3'h2: tmo_cyc = 250 * MS_TICK_CYCLES;
         3'h3: tmo_cyc = 500 * MS_TICK_CYCLES;
         3'h4: tmo_cyc = 750 * MS_TICK_CYCLES;
         3'h5: tmo_cyc = 1000 * MS_TICK_CYCLES;
         3'h6: tmo_cyc = 2000 * MS_TICK_CYCLES;
         default: tmo_cyc = 0;
      endcase
      tog_cyc = (350 + 10 * int'(tog_q)) * MS_TICK_CYCLES;
   end

   // shadow registers, low-time and stuck-time counters
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tog_q   <= TOGGLE_RESET;
         tmo_q   <= TIMEOUT_RESET;
         lnk_d   <= 4'h0;
         low_cnt <= 0;
         stk_cnt <= 0;
      end else begin
         if (otp_timeout_load_i) tmo_q <= otp_timeout_i[2:0];
         else if (cfg_wr_i && cfg_addr_i == REG_TIMEOUT) tmo_q <= cfg_wdata_i[2:0];
         if (cfg_wr_i && cfg_addr_i == REG_TOGGLE) tog_q <= cfg_wdata_i;
         lnk_d   <= port3_link_state_status_i;
         low_cnt <= (port3_option_a_pin_oe_o && !port3_option_a_pin_o) ? low_cnt + 1 : 0;
         stk_cnt <= (p3a_up && port3_link_state_status_i == lnk_d &&
                     port3_link_state_status_i inside {[LINK_STUCK_LO:LINK_STUCK_HI]}) ?
                    stk_cnt + 1 : 0;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_RVALID_NEXT: assert property (cfg_rd_i |=> cfg_rvalid_o)
      else $error("read not answered next cycle");
   AST_RDATA_IDLE_ZERO: assert property (!cfg_rvalid_o |-> cfg_rdata_o == 8'h00)
      else $error("read data not zero while idle");
   AST_TMO_UPPER_ZERO: assert property (cfg_rd_i && cfg_addr_i == REG_TIMEOUT |=> cfg_rdata_o[7:3] == 5'h00)
      else $error("timeout upper bits not zero");
   AST_USB2_FOLLOWS: assert property ($past(rst_n_i) |-> port_power_ctl_pin_o == $past(usb2_power_req_i))
      else $error("usb2 power pin not a copy of its request");
   AST_OFF_UNSELECTED: assert property (!port3_option_a_pin_oe_o || !port4_option_b_pin_oe_o |-> (port3_option_a_pin_oe_o || !port3_option_a_pin_o) && (port4_option_b_pin_oe_o || !port4_option_b_pin_o))
      else $error("split pin high while not selected");
   AST_P3_OPT_A_SELECT: assert property (cfg_wr_i && cfg_addr_i == REG_P3_SEL && cfg_wdata_i == P3_SEL_OPT_A |-> ##[1:3] port3_option_a_pin_oe_o)
      else $error("port 3 option a not selected");
   AST_P4_OPT_B_SELECT: assert property (cfg_wr_i && cfg_addr_i == REG_P4_SEL && cfg_wdata_i == P4_SEL_OPT_B |-> ##[1:3] port4_option_b_pin_oe_o)
      else $error("port 4 option b not selected");
   AST_PULSE_LENGTH: assert property ($rose(port3_option_a_pin_o) && port3_option_a_pin_oe_o && $past(low_cnt) > 16 |-> $past(low_cnt) + MS_TICK_CYCLES + 2 >= tog_cyc && $past(low_cnt) <= tog_cyc + 3)
      else $error("power-off pulse length wrong");
   AST_NO_EARLY_PULSE: assert property ($fell(port3_option_a_pin_o) && port3_option_a_pin_oe_o |-> tmo_q inside {[3'h1:3'h6]} && stk_cnt + 2 * MS_TICK_CYCLES + 6 >= tmo_cyc)
      else $error("pulse without a full stuck timeout");
   AST_PULSE_DUE: assert property (tmo_q inside {[3'h1:3'h6]} && stk_cnt > tmo_cyc + 2 * MS_TICK_CYCLES + 8 |-> !port3_option_a_pin_o)
      else $error("stuck link not pulsed in time");

   // main scenarios reached
   COV_READ: cover property (cfg_rvalid_o);
   COV_PULSE_START: cover property ($fell(port3_option_a_pin_o) && port3_option_a_pin_oe_o);
   COV_PULSE_END: cover property ($rose(port3_option_a_pin_o) && low_cnt == 0 && $past(low_cnt) > 16);
endmodule // psw_monitor

bind psw_port_split_wd psw_monitor #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) u_mon (.clk_i, .rst_n_i,
   .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_rvalid_o, .otp_timeout_load_i,
   .otp_timeout_i, .usb2_power_req_i, .port_power_ctl_pin_o, .port3_link_state_status_i,
   .port3_option_a_pin_o, .port3_option_a_pin_oe_o, .port4_option_b_pin_o, .port4_option_b_pin_oe_o);

`default_nettype wire

// ### testbench/psw_ss_device_model.sv
// embedded superspeed device behind the split power switch
// assumes power is the split pin level gated by its enable
`timescale 1ns/100ps
`default_nettype none

module psw_ss_device_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       power_i,
   input  wire logic       link_good_i,
   output logic      [3:0] link_state_o
);
   logic [1:0] walk;

   // unpowered: receiver detect; healthy: walks states; broken: stuck in polling
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         walk         <= 2'h0;
         link_state_o <= 4'h5;
      end else begin
         walk         <= walk + 2'h1;
         link_state_o <= !power_i ? 4'h5 : (link_good_i ? {2'h0, walk} : 4'h7);
      end
   end
endmodule // psw_ss_device_model

`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the port-split link watchdog
// assumes a 10 MHz clock and a 2-cycle millisecond tick
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin fail_count++; $display("CHECK FAILED %0t %s", $time, msg); end end

module tb;
   import psw_pkg::*;
   localparam int MS = 2;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        cfg_wr_i = 1'b0;
   logic        cfg_rd_i = 1'b0;
   logic [15:0] cfg_addr_i = 16'h0000;
   logic [7:0]  cfg_wdata_i = 8'h00;
   logic        otp_timeout_load_i = 1'b0;
   logic [7:0]  otp_timeout_i = 8'h00;
   logic [1:0]  usb2_power_req_i = 2'h0;
   logic [3:0]  port4_link_state_status_i = 4'h6;
   logic        link_good = 1'b1;
   logic [7:0]  cfg_rdata_o;
   logic        cfg_rvalid_o;
   logic [1:0]  port_power_ctl_pin_o;
   logic [3:0]  port3_link_state_status_i;
   logic        port3_option_a_pin_o, port3_option_a_pin_oe_o, port3_option_b_pin_o;
   logic        port3_option_b_pin_oe_o, port4_option_a_pin_o, port4_option_a_pin_oe_o;
   logic        port4_option_b_pin_o, port4_option_b_pin_oe_o;
   int          fail_count = 0;
   int          num_checks = 0;
   wire [3:0]   pins = {port3_option_a_pin_o, port3_option_b_pin_o, port4_option_a_pin_o, port4_option_b_pin_o};
   wire [3:0]   oes = {port3_option_a_pin_oe_o, port3_option_b_pin_oe_o, port4_option_a_pin_oe_o, port4_option_b_pin_oe_o};

   psw_port_split_wd #(.MS_TICK_CYCLES(MS)) u_dut (.clk_i, .rst_n_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i,
      .cfg_wdata_i, .cfg_rdata_o, .cfg_rvalid_o, .otp_timeout_load_i, .otp_timeout_i, .usb2_power_req_i,
      .port_power_ctl_pin_o, .port3_link_state_status_i, .port4_link_state_status_i,
      .port3_option_a_pin_o, .port3_option_a_pin_oe_o, .port3_option_b_pin_o, .port3_option_b_pin_oe_o,
      .port4_option_a_pin_o, .port4_option_a_pin_oe_o, .port4_option_b_pin_o, .port4_option_b_pin_oe_o);

   psw_ss_device_model u_dev (.clk_i, .rst_n_i, .power_i(port3_option_a_pin_o & port3_option_a_pin_oe_o),
      .link_good_i(link_good), .link_state_o(port3_link_state_status_i));

   // core clock
   always #50 clk_i = ~clk_i;

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cfg_wr_i    <= 1'b1;
      cfg_addr_i  <= a;
      cfg_wdata_i <= d;
      @(posedge clk_i);
      cfg_wr_i    <= 1'b0;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string m);
      @(posedge clk_i);
      cfg_rd_i   <= 1'b1;
      cfg_addr_i <= a;
      @(posedge clk_i);
      cfg_rd_i   <= 1'b0;
      @(negedge clk_i);
      `CHK({cfg_rvalid_o, cfg_rdata_o}, {1'b1, e}, m)
   endtask

   task automatic wait_pin(input int idx, input logic lvl, input int lim, output int n);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (pins[idx] !== lvl && n < lim);
      if (n >= lim) begin
         fail_count++;
         $display("CHECK FAILED %0t wait ran out", $time);
         give_verdict();
      end
   endtask

   task automatic t_regs();
      rd_chk(REG_P3_SEL, 8'h00, "port 3 select reset");
      rd_chk(REG_TIMEOUT, 8'h05, "timeout reset");
      rd_chk(REG_TOGGLE, 8'h05, "toggle reset");
      wr(REG_TIMEOUT, 8'hFF);
      rd_chk(REG_TIMEOUT, 8'h07, "timeout upper bits");
      wr(16'h4172, 8'hAA);
      rd_chk(16'h4172, 8'h00, "unmapped read");
      @(posedge clk_i);
      otp_timeout_load_i <= 1'b1;
      otp_timeout_i      <= 8'hFB;
      cfg_addr_i         <= REG_TIMEOUT;
      cfg_wr_i           <= 1'b1;
      cfg_wdata_i        <= 8'h01;
      @(posedge clk_i);
      otp_timeout_load_i <= 1'b0;
      cfg_wr_i           <= 1'b0;
      rd_chk(REG_TIMEOUT, 8'h03, "otp timeout override");
      wr(REG_TOGGLE, 8'hFF);
      rd_chk(REG_TOGGLE, 8'hFF, "toggle longest");
   endtask

   task automatic t_select();
      logic [7:0] codes [4] = '{P3_SEL_OPT_A, P3_SEL_OPT_B, P4_SEL_OPT_A, P4_SEL_OPT_B};
      for (int i = 0; i < 4; i++) begin
         wr(i < 2 ? REG_P3_SEL : REG_P4_SEL, codes[i]);
         repeat (4) @(negedge clk_i);
         `CHK(oes, 4'h8 >> i, "pin select")
         `CHK(pins, 4'h8 >> i, "split power on")
         wr(i < 2 ? REG_P3_SEL : REG_P4_SEL, 8'h00);
      end
      wr(REG_P3_SEL, P3_SEL_OPT_A);
      for (int j = 0; j < 4; j++) begin
         @(posedge clk_i);
         usb2_power_req_i <= 2'(j);
         @(posedge clk_i);
         @(negedge clk_i);
         `CHK(port_power_ctl_pin_o, 2'(j), "usb2 power pin")
      end
      wr(REG_P3_SEL, 8'h41);
      repeat (4) @(negedge clk_i);
      `CHK(oes, 4'h0, "unknown select code")
   endtask

   task automatic t_pulse();
      int n;
      int lows;
      @(posedge clk_i);
      link_good <= 1'b0;
      wr(REG_TIMEOUT, 8'h01);
      wr(REG_TOGGLE, 8'h00);
      wr(REG_P3_SEL, P3_SEL_OPT_A);
      wait_pin(3, 1'b1, 20, n);
      wait_pin(3, 1'b0, 400, n);
      `CHK(n inside {[100*MS-10:100*MS+10]}, 1'b1, "first timeout")
      wait_pin(3, 1'b1, 800, n);
      `CHK(n inside {[350*MS-10:350*MS+10]}, 1'b1, "pulse length")
      wait_pin(3, 1'b0, 400, n);
      `CHK(n inside {[100*MS-10:100*MS+10]}, 1'b1, "restarted timeout")
      wait_pin(3, 1'b1, 800, n);
      @(posedge clk_i);
      link_good <= 1'b1;
      lows = 0;
      repeat (600) begin
         @(negedge clk_i);
         lows += (pins[3] !== 1'b1);
      end
      `CHK(lows, 0, "healthy link not pulsed")
      wr(REG_P3_SEL, 8'h00);
   endtask

   task automatic t_codes();
      int ms_tab [8] = '{0, 100, 250, 500, 750, 1000, 2000, 0};
      int n;
      int lows;
      for (int k = 0; k < 8; k++) begin
         wr(REG_TIMEOUT, 8'(k));
         wr(REG_P4_SEL, P4_SEL_OPT_B);
         wait_pin(0, 1'b1, 20, n);
         if (ms_tab[k] == 0) begin
            lows = 0;
            repeat (800) begin
               @(negedge clk_i);
               lows += (pins[0] !== 1'b1);
            end
            `CHK(lows, 0, "no timeout never pulses")
         end else begin
            wait_pin(0, 1'b0, ms_tab[k] * MS + 20, n);
            `CHK(n inside {[ms_tab[k]*MS-10:ms_tab[k]*MS+10]}, 1'b1, "timeout length")
         end
         wr(REG_P4_SEL, 8'h00);
         repeat (3) @(negedge clk_i);
         `CHK({oes[0], pins[0]}, 2'b00, "split off")
      end
   endtask

   // reset, then the scenarios in turn
   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_select();
      t_pulse();
      t_codes();
      give_verdict();
   end
endmodule // tb

`default_nettype wire
